// ### hw/imlu_defines.vh
// opcode, field and width constants for the multiply and logic unit
`ifndef IMLU_DEFINES_VH
`define IMLU_DEFINES_VH
`define IMLU_WORD_W 32
`define IMLU_IDX_W 8
`define IMLU_F_OPC 31:24
`define IMLU_F_DST 23:16
`define IMLU_F_FIRST_SOURCE 15:8
`define IMLU_F_SECOND_SOURCE 7:0
`define IMLU_F_OPC_BASE 31:25
`define IMLU_OP_MUL_LO 8'he0
`define IMLU_OP_MUL_HI_S 8'hde
`define IMLU_OP_MUL_HI_U 8'hdf
`define IMLU_OP_STEP 7'h3a
`define IMLU_OP_NOR 7'h4c
`define IMLU_OP_NAND 7'h4d
`define IMLU_ZERO_WORD 32'h0000_0000
`define IMLU_IMM_PAD 24'h00_0000
`endif

// ### hw/imlu_regfile.v
// register file with two registered read ports and one write port
`timescale 1ns/1ps
module imlu_regfile #(
  parameter IDX_W = 8,
  parameter WORD_W = 32
) (
  input wire clock,
  input wire sys_rst,
  input wire [IDX_W-1:0] read_a_index,
  input wire [IDX_W-1:0] read_b_index,
  output reg [WORD_W-1:0] read_a_data,
  output reg [WORD_W-1:0] read_b_data,
  input wire write_enable,
  input wire [IDX_W-1:0] write_index,
  input wire [WORD_W-1:0] write_data
);
  reg [WORD_W-1:0] storage [0:(1<<IDX_W)-1];

  always @(posedge clock) begin
    if (write_enable) begin
      storage[write_index] <= write_data;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      read_a_data <= {WORD_W{1'b0}};
      read_b_data <= {WORD_W{1'b0}};
    end else begin
      read_a_data <= storage[read_a_index];
      read_b_data <= storage[read_b_index];
    end
  end
endmodule

// ### hw/imlu_unit.v
// two-stage multiply, multiply-step and nand/nor execution unit
//
// Summary of operation
// (RL1) e0: signed multiply, low 32 product bits to result, flags untouched
// (RL2) de: signed multiply, high 32 product bits to result, flags untouched
// (RL3) df: unsigned multiply, high 32 product bits to result, flags kept
// (RL4) step register content is undefined after full multiplies
// (RL5) step adds first source when step bit 0 set, else zero
// (RL6) sum and step register shifted right one, carry fills top bit
// (RL7) high shifted half to result, low half back to step register
// (RL8) step updates v n z c; full multiplies leave flags alone
// (RL9) step and logic second source: register, or zero-extended immediate
// (RL10) nand writes complement of bitwise and of both sources
// (RL11) nor writes complement of bitwise or, updates only n and z
// (RL12) instruction fields: opcode, destination, first source, second source
// (RL13) n copies result bit 31, z set when result is zero
`timescale 1ns/1ps
`include "imlu_defines.vh"
module imlu_unit #(
  parameter IDX_W = `IMLU_IDX_W,
  parameter WORD_W = `IMLU_WORD_W
) (
  input wire clock,
  input wire sys_rst,
  input wire instr_valid,
  input wire [31:0] instr_word,
  input wire load_valid,
  input wire [IDX_W-1:0] load_index,
  input wire [WORD_W-1:0] load_data,
  output reg result_valid,
  output reg [IDX_W-1:0] result_index,
  output reg [WORD_W-1:0] result_data,
  output reg unsupported,
  output reg flag_v,
  output reg flag_n,
  output reg flag_z,
  output reg flag_c,
  output reg [WORD_W-1:0] step_value
);
  // opcode match ignoring the operand kind bit
  function match_base;
    input [7:0] opc;
    input [6:0] base;
    begin
      match_base = (opc[7:1] == base);
    end
  endfunction

  // zero test of a written result
  function is_zero;
    input [WORD_W-1:0] word;
    begin
      is_zero = (word == {WORD_W{1'b0}});
    end
  endfunction

  reg ex_valid;
  reg [7:0] ex_opc;
  reg [IDX_W-1:0] ex_dst;
  reg [IDX_W-1:0] ex_a_idx;
  reg [IDX_W-1:0] ex_b_idx;
  reg [7:0] ex_imm;
  reg wr_valid;
  reg [IDX_W-1:0] wr_index;
  reg [WORD_W-1:0] wr_data;
  wire [WORD_W-1:0] rf_a;
  wire [WORD_W-1:0] rf_b;
  reg [WORD_W-1:0] first_source;
  reg [WORD_W-1:0] second_source;
  reg [WORD_W-1:0] reg_b;
  reg [WORD_W-1:0] addend;
  reg [WORD_W:0] step_sum;
  reg [63:0] prod_s;
  reg [63:0] prod_u;
  reg [WORD_W-1:0] next_result;
  reg next_write;
  reg next_unsupported;
  reg next_nz;
  reg next_vc;
  reg next_step_wr;
  reg next_v;
  reg next_c;
  reg [WORD_W-1:0] next_step;
  wire operand_kind_flag;
  wire exec_write;
  wire rf_we;
  wire [IDX_W-1:0] rf_widx;
  wire [WORD_W-1:0] rf_wdata;

  assign operand_kind_flag = ex_opc[0];
  assign exec_write = ex_valid & next_write;
  assign rf_we = exec_write | load_valid;
  assign rf_widx = exec_write ? ex_dst : load_index;
  assign rf_wdata = exec_write ? next_result : load_data;

  imlu_regfile #(
    .IDX_W(IDX_W),
    .WORD_W(WORD_W)
  ) u_regfile (
    .clock(clock),
    .sys_rst(sys_rst),
    .read_a_index(instr_word[`IMLU_F_FIRST_SOURCE]), // [RL12]
    .read_b_index(instr_word[`IMLU_F_SECOND_SOURCE]), // [RL12]
    .read_a_data(rf_a),
    .read_b_data(rf_b),
    .write_enable(rf_we),
    .write_index(rf_widx),
    .write_data(rf_wdata)
  );

  // decode stage
  always @(posedge clock) begin
    if (sys_rst) begin
      ex_valid <= 1'b0;
      ex_opc <= 8'h00;
      ex_dst <= {IDX_W{1'b0}};
      ex_a_idx <= {IDX_W{1'b0}};
      ex_b_idx <= {IDX_W{1'b0}};
      ex_imm <= 8'h00;
    end else begin
      ex_valid <= instr_valid;
      ex_opc <= instr_word[`IMLU_F_OPC]; // [RL12]
      ex_dst <= instr_word[`IMLU_F_DST]; // [RL12]
      ex_a_idx <= instr_word[`IMLU_F_FIRST_SOURCE];
      ex_b_idx <= instr_word[`IMLU_F_SECOND_SOURCE];
      ex_imm <= instr_word[`IMLU_F_SECOND_SOURCE];
    end
  end

  // last write tracking for forwarding
  always @(posedge clock) begin
    if (sys_rst) begin
      wr_valid <= 1'b0;
      wr_index <= {IDX_W{1'b0}};
      wr_data <= `IMLU_ZERO_WORD;
    end else begin
      wr_valid <= rf_we;
      wr_index <= rf_widx;
      wr_data <= rf_wdata;
    end
  end

  // operand select with forwarding
  always @* begin
    first_source = rf_a;
    reg_b = rf_b;
    if (wr_valid && wr_index == ex_a_idx) begin
      first_source = wr_data;
    end
    if (wr_valid && wr_index == ex_b_idx) begin
      reg_b = wr_data;
    end
    second_source = reg_b;
    if (operand_kind_flag && (match_base(ex_opc, `IMLU_OP_STEP) ||
        match_base(ex_opc, `IMLU_OP_NOR) ||
        match_base(ex_opc, `IMLU_OP_NAND))) begin
      second_source = {`IMLU_IMM_PAD, ex_imm}; // [RL9]
    end
  end

  // execute
  always @* begin
    prod_s = $signed(first_source) * $signed(reg_b);
    prod_u = first_source * reg_b;
    addend = step_value[0] ? first_source : `IMLU_ZERO_WORD; // [RL5]
    step_sum = {1'b0, second_source} + {1'b0, addend}; // [RL5]
    next_result = `IMLU_ZERO_WORD;
    next_write = 1'b1;
    next_unsupported = 1'b0;
    next_nz = 1'b0;
    next_vc = 1'b0;
    next_step_wr = 1'b0;
    next_v = flag_v;
    next_c = flag_c;
    next_step = step_value;
    case (ex_opc)
      `IMLU_OP_MUL_LO: begin
        next_result = prod_s[31:0]; // [RL1] [RL4] [RL8]
      end
      `IMLU_OP_MUL_HI_S: begin
        next_result = prod_s[63:32]; // [RL2] [RL4] [RL8]
      end
      `IMLU_OP_MUL_HI_U: begin
        next_result = prod_u[63:32]; // [RL3] [RL4] [RL8]
      end
      default: begin
        if (match_base(ex_opc, `IMLU_OP_STEP)) begin
          // [RL6] [RL7]
          next_result = {step_sum[WORD_W], step_sum[WORD_W-1:1]};
          next_step = {step_sum[0], step_value[WORD_W-1:1]};
          next_step_wr = 1'b1;
          next_nz = 1'b1;
          next_vc = 1'b1; // [RL8]
          next_c = step_sum[WORD_W];
          next_v = (addend[31] == second_source[31]) &&
                   (step_sum[31] != second_source[31]);
        end else if (match_base(ex_opc, `IMLU_OP_NOR)) begin
          next_result = ~(first_source | second_source); // [RL11]
          next_nz = 1'b1;
        end else if (match_base(ex_opc, `IMLU_OP_NAND)) begin
          next_result = ~(first_source & second_source); // [RL10]
          next_nz = 1'b1;
        end else begin
          next_write = 1'b0;
          next_unsupported = 1'b1;
        end
      end
    endcase
  end

  // result, flag and step register update
  always @(posedge clock) begin
    if (sys_rst) begin
      result_valid <= 1'b0;
      result_index <= {IDX_W{1'b0}};
      result_data <= `IMLU_ZERO_WORD;
      unsupported <= 1'b0;
      flag_v <= 1'b0;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
      flag_c <= 1'b0;
      step_value <= `IMLU_ZERO_WORD;
    end else begin
      result_valid <= exec_write;
      unsupported <= ex_valid & next_unsupported;
      if (exec_write) begin
        result_index <= ex_dst;
        result_data <= next_result;
      end
      if (ex_valid && next_nz) begin
        flag_n <= next_result[31]; // [RL13]
        flag_z <= is_zero(next_result); // [RL13]
      end
      if (ex_valid && next_vc) begin
        flag_v <= next_v; // [RL8]
        flag_c <= next_c;
      end
      if (ex_valid && next_step_wr) begin
        step_value <= next_step; // [RL7]
      end
    end
  end
endmodule

// ### tb/imlu_unit_chk.sv
// assertion checker for the multiply and logic unit
`timescale 1ns/1ps
`include "imlu_defines.vh"
module imlu_unit_chk #(
  parameter IDX_W = 8,
  parameter WORD_W = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic result_valid,
  input wire logic [IDX_W-1:0] result_index,
  input wire logic [WORD_W-1:0] result_data,
  input wire logic unsupported,
  input wire logic flag_v,
  input wire logic flag_n,
  input wire logic flag_z,
  input wire logic flag_c,
  input wire logic [WORD_W-1:0] step_value
);
  localparam int LAT = 2;
  wire [6:0] base = instr_word[`IMLU_F_OPC_BASE];
  wire [7:0] opc = instr_word[`IMLU_F_OPC];
  wire stp = instr_valid && base == `IMLU_OP_STEP;
  wire lgc = instr_valid && (base == `IMLU_OP_NOR || base == `IMLU_OP_NAND);
  wire mul = instr_valid && (opc == `IMLU_OP_MUL_LO ||
    opc == `IMLU_OP_MUL_HI_S || opc == `IMLU_OP_MUL_HI_U);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence go_known;
    stp || lgc || mul;
  endsequence
  sequence go_nz;
    stp || lgc;
  endsequence
  latency_ok_a: assert property (go_known |-> ##LAT result_valid)
    else $error("result pulse missing");
  refuse_unknown_a: assert property (instr_valid &&
    !(stp || lgc || mul) |-> ##LAT unsupported && !result_valid)
    else $error("bad opcode taken");
  idle_quiet_a: assert property (!instr_valid |->
    ##LAT !result_valid) else $error("result without instruction");
  result_register_index_a: assert property (go_known |-> ##LAT
    result_index == $past(instr_word[23:16], LAT)) else $error("wrong index");
  mul_flags_a: assert property (mul |-> ##LAT
    $stable({flag_v, flag_n, flag_z, flag_c})) else $error("flags moved");
  logic_vc_a: assert property (lgc |->
    ##LAT $stable({flag_v, flag_c})) else $error("v or c moved");
  nz_follow_a: assert property (go_nz |-> ##LAT
    flag_n == result_data[31] && flag_z == (result_data == 32'h0))
    else $error("n or z wrong");
  step_carry_a: assert property (stp |-> ##LAT
    result_data[31] == flag_c) else $error("top bit not carry");
  step_shift_a: assert property (stp |-> ##LAT
    step_value[30:0] == $past(step_value[31:1])) else $error("step shift");
endmodule
bind imlu_unit imlu_unit_chk #(.IDX_W(IDX_W), .WORD_W(WORD_W)) i_chk (
  .clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid),
  .instr_word(instr_word), .result_valid(result_valid),
  .result_index(result_index), .result_data(result_data),
  .unsupported(unsupported), .flag_v(flag_v), .flag_n(flag_n),
  .flag_z(flag_z), .flag_c(flag_c), .step_value(step_value));

// ### tb/tb_imlu_unit.sv
// self-checking bench for the multiply and logic unit
`timescale 1ns/1ps
module tb_imlu_unit;
  logic clock = 0, sys_rst = 1, instr_valid = 0, load_valid = 0, qk;
  logic [31:0] instr_word = 32'h0, load_data = 32'h0, q;
  logic [7:0] load_index = 8'h0;
  wire result_valid, unsupported, flag_v, flag_n, flag_z, flag_c;
  wire [7:0] result_index;
  wire [31:0] result_data, step_value;
  logic [31:0] rf [0:255];
  logic [3:0] fl;
  logic [7:0] ops [0:8] = '{8'h74, 8'h75, 8'h98, 8'h99, 8'h9a, 8'h9b,
    8'he0, 8'hde, 8'hdf};
  int err_count = 0, check_count = 0, i, s;
  imlu_unit i_imlu_unit (.clock(clock), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .load_valid(load_valid), .load_index(load_index), .load_data(load_data),
    .result_valid(result_valid), .result_index(result_index),
    .result_data(result_data), .unsupported(unsupported), .flag_v(flag_v),
    .flag_n(flag_n), .flag_z(flag_z), .flag_c(flag_c),
    .step_value(step_value));
  function logic [7:0] rb;
    return 8'($urandom);
  endfunction
  task chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wrap_up;
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task rst;
    sys_rst = 1;
    q = 32'h0;
    qk = 1;
    fl = 4'h0;
    repeat (3) @(posedge clock);
    #1 sys_rst = 0;
  endtask
  function void model(input logic [7:0] op, d, a, b,
    output logic [31:0] r, output logic ok);
    logic [31:0] sa, sb, ad, sm;
    logic [63:0] p;
    logic c, mul;
    mul = op == 8'he0 || op == 8'hde || op == 8'hdf;
    ok = 1;
    r = 32'h0;
    sa = rf[a];
    sb = op[0] && !mul ? {24'h0, b} : rf[b];
    ad = q[0] ? sa : 32'h0;
    {c, sm} = ad + sb;
    p = {{32{sa[31]}}, sa} * {{32{sb[31]}}, sb};
    if (op == 8'hdf)
      p = {32'h0, sa} * {32'h0, sb};
    case (op)
      8'he0: r = p[31:0];
      8'hde, 8'hdf: r = p[63:32];
      8'h74, 8'h75: begin
        r = {c, sm[31:1]};
        fl = {ad[31] == sb[31] && sm[31] != ad[31], r[31], r == 32'h0, c};
        q = {sm[0], q[31:1]};
      end
      8'h98, 8'h99: r = ~(sa | sb);
      8'h9a, 8'h9b: r = ~(sa & sb);
      default: ok = 0;
    endcase
    if (ok && !mul)
      fl[2:1] = {r[31], r == 32'h0};
    if (mul)
      qk = 0;
    if (ok)
      rf[d] = r;
  endfunction
  task chk_state;
    chk("flags", {28'h0, fl},
      {28'h0, flag_v, flag_n, flag_z, flag_c});
    if (qk)
      chk("step", q, step_value);
  endtask
  task run(input logic [7:0] op, d, a, b);
    logic [31:0] r;
    logic ok;
    int n;
    model(op, d, a, b, r, ok);
    @(posedge clock) #1;
    instr_valid = 1;
    instr_word = {op, d, a, b};
    @(posedge clock) #1;
    instr_valid = 0;
    for (n = 0; n < 9 && result_valid !== 1 && unsupported !== 1; n++)
      @(posedge clock) #1;
    if (n == 9) begin
      err_count++;
      wrap_up;
    end
    chk("valid", {31'h0, ok}, {31'h0, result_valid});
    if (ok) begin
      chk("result", r, result_data);
      chk("index", {24'h0, d}, {24'h0, result_index});
    end
    chk_state;
  endtask
  task pair(input logic [7:0] o1, d1, a1, b1, o2, d2, a2, b2);
    logic [31:0] r1, r2;
    logic k1, k2;
    model(o1, d1, a1, b1, r1, k1);
    model(o2, d2, a2, b2, r2, k2);
    @(posedge clock) #1;
    instr_valid = 1;
    instr_word = {o1, d1, a1, b1};
    @(posedge clock) #1;
    instr_word = {o2, d2, a2, b2};
    @(posedge clock) #1;
    instr_valid = 0;
    chk("first valid", {31'h0, k1}, {31'h0, result_valid});
    chk("first result", r1, result_data);
    @(posedge clock) #1;
    chk("second valid", {31'h0, k2}, {31'h0, result_valid});
    chk("second result", r2, result_data);
    chk("second index", {24'h0, d2}, {24'h0, result_index});
    chk_state;
  endtask
  initial begin
    forever #5 clock = ~clock;
  end
  initial begin
    s = $urandom(25);
    rst;
    load_valid = 1;
    for (i = 0; i < 256; i++) begin
      load_index = i[7:0];
      load_data = i == 1 ? 32'h8000_0000 : i == 2 ? 32'hffff_ffff : $urandom;
      rf[i] = load_data;
      @(posedge clock) #1;
    end
    load_valid = 0;
    run(8'h75, 8'h10, 8'h2, 8'hff);
    for (i = 0; i < 200; i++)
      run(ops[$urandom % 6], 8'h8 | rb(), rb(), rb());
    for (i = 0; i < 40; i++)
      pair(ops[$urandom % 6], 8'h20, rb(), rb(),
        ops[$urandom % 6], 8'h21, 8'h20, 8'h20);
    for (i = 6; i < 9; i++) begin
      run(ops[i], 8'h4, 8'h1, 8'h2);
      run(ops[i], 8'h5, 8'h2, 8'h2);
      run(ops[i], 8'h6, 8'h1, 8'h1);
    end
    for (i = 0; i < 60; i++)
      run(ops[6 + $urandom % 3], 8'h8 | rb(), rb(), rb());
    pair(8'h98, 8'h22, 8'h1, 8'h8, 8'hde, 8'h23, 8'h22, 8'h22);
    rst;
    run(8'h00, 8'h9, 8'h1, 8'h2);
    for (i = 0; i < 30; i++)
      run(ops[$urandom % 2], 8'h8 | rb(), rb(), rb());
    wrap_up;
  end
endmodule
